//--- hw/dls_pkg.sv
// Shared constants and types for the serial display link lane controller.
// Assumes a 40 MHz reference clock; all lane timing derives from it.
package dls_pkg;
  localparam int CLK_PERIOD_NS = 25;
  // Least hold time of one low-power line state
  localparam int T_LPX_NS      = 50;
  localparam int LPX_CYC       = (T_LPX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W         = 4;
  localparam int NUM_LANES     = 3;
  localparam int LANE_CLK      = 0;
  localparam int LANE_D0       = 1;
  localparam int LANE_D1       = 2;
  localparam int MAX_STEPS     = 24;
  localparam int ESC_LEN       = 20;
  localparam int EXIT_LEN      = 2;
  localparam int HS_BITS       = 8;

  // Step code {hs, p, n}
  localparam logic [2:0] S_LP00 = 3'h0;
  localparam logic [2:0] S_LP01 = 3'h1;
  localparam logic [2:0] S_LP10 = 3'h2;
  localparam logic [2:0] S_LP11 = 3'h3;
  localparam logic [2:0] S_HS0  = 3'h5;

  localparam logic [7:0] ESC_ULPS = 8'h1e;

  localparam logic [2:0] CMD_HS_ENTER  = 3'h1;
  localparam logic [2:0] CMD_HS_EXIT   = 3'h2;
  localparam logic [2:0] CMD_ULP_ENTER = 3'h3;
  localparam logic [2:0] CMD_ULP_EXIT  = 3'h4;
  localparam logic [2:0] CMD_ESC       = 3'h5;

  typedef enum {ST_STOP, ST_SEQ, ST_HS, ST_ULP} dls_st_e;
  typedef logic [MAX_STEPS-1:0][2:0] dls_steps_t;
endpackage : dls_pkg

//--- hw/dls_tmr_if.sv
// Start/done pair between a lane sequencer and its state-hold timer.
// Both ends run on the same reference clock.
`timescale 1ns/1ps
`default_nettype none
interface dls_tmr_if;
  logic start;
  logic done;
  modport owner (output start, input done);
  modport timer (input start, output done);
endinterface : dls_tmr_if
`default_nettype wire

//--- hw/dls_lpx_timer.sv
// Hold timer for one low-power line state; done pulses LPX_CYC cycles after start.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module dls_lpx_timer
  import dls_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  dls_tmr_if.timer  t
);
  localparam logic [TMR_W-1:0] LOAD = TMR_W'(LPX_CYC);
  logic [TMR_W-1:0] cnt_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (t.start)
      cnt_q <= LOAD;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign t.done = (cnt_q == TMR_W'(1));
endmodule : dls_lpx_timer
`default_nettype wire

//--- hw/dls_sync2.sv
// Two-flop level synchroniser for pins from outside the clock domain.
// The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module dls_sync2
  import dls_pkg::*;
#(
  parameter int W = 2
)
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : dls_sync2
`default_nettype wire

//--- hw/dls_host_ctrl.sv
// Host end of a serial display link: one clock lane and two data lanes.
// Drives lane line states, escape sequences and high-speed bursts on request.
// Assumes pad cells pick the high-speed driver when lane_hs is high.
`timescale 1ns/1ps
`default_nettype none
module dls_host_ctrl
  import dls_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_lane,
  input  wire logic [2:0] cmd_code,
  input  wire logic [7:0] cmd_esc,
  output logic            cmd_done,
  output logic            cmd_refused,
  input  wire logic [7:0] hs_byte0,
  input  wire logic [7:0] hs_byte1,
  output logic      [1:0] hs_take,
  output logic      [2:0] lane_p,
  output logic      [2:0] lane_n,
  output logic      [2:0] lane_oe,
  output logic      [2:0] lane_hs,
  output logic      [2:0] lane_busy,
  input  wire logic       lane0_rx_p,
  input  wire logic       lane0_rx_n,
  output logic      [1:0] lane0_rx_state,
  output logic            clock_low_power_mode,
  output logic            clock_ultra_low_power_mode,
  output logic            clock_high_speed_mode
);
  dls_st_e          st_arr   [NUM_LANES];
  logic [NUM_LANES-1:0] acc_w;
  logic [NUM_LANES-1:0] fin_w;
  logic [NUM_LANES-1:0] take_w;
  logic [1:0]           rx_sync;
  logic [7:0]           hs_byte [NUM_LANES];

  assign hs_byte[LANE_CLK] = '0;
  assign hs_byte[LANE_D0]  = hs_byte0;
  assign hs_byte[LANE_D1]  = hs_byte1;

  // Escape entry, command bits first to last, each a mark then a space
  function automatic dls_steps_t esc_steps(input logic [7:0] b);
    dls_steps_t s;
    s    = '0;
    s[0] = S_LP10;
    s[1] = S_LP00;
    s[2] = S_LP01;
    s[3] = S_LP00;
    for (int k = 0; k < 8; k++)
    begin
      s[4 + 2*k] = b[7-k] ? S_LP10 : S_LP01;
      s[5 + 2*k] = S_LP00;
    end
    return s;
  endfunction : esc_steps

  wire clk_hs_idle = (st_arr[LANE_CLK] == ST_HS);
  wire data_quiet  = (st_arr[LANE_D0] inside {ST_STOP, ST_ULP}) &&
                     (st_arr[LANE_D1] inside {ST_STOP, ST_ULP});

  for (genvar i = 0; i < NUM_LANES; i++)
  begin : g_lane
    localparam bit IS_CLK = (i == LANE_CLK);
    dls_tmr_if tif ();
    dls_lpx_timer u_tmr (
      .ref_clk (ref_clk),
      .rst     (rst),
      .t       (tif.timer)
    );

    dls_st_e      st_q;
    dls_st_e      nxt_q;
    dls_st_e      ld_nxt;
    dls_steps_t   steps_q;
    dls_steps_t   ld_steps;
    logic [4:0]   len_q;
    logic [4:0]   ld_len;
    logic [4:0]   idx_q;
    logic [1:0]   pn_q;
    logic         hs_q;
    logic         oe_q;
    logic         start_q;
    logic         take_q;
    logic         fin_q;
    logic         busy_q;
    logic [7:0]   sh_q;
    logic [2:0]   bit_q;

    wire sel      = cmd_valid && (cmd_lane == 2'(i));
    wire ok_hs_in = (st_q == ST_STOP) && (IS_CLK || clk_hs_idle);
    wire ok_hs_out = (st_q == ST_HS) && (!IS_CLK || data_quiet);
    wire ok_esc   = (st_q == ST_STOP) && (i == LANE_D0);
    wire ok = sel && ((cmd_code == CMD_HS_ENTER && ok_hs_in) ||
                      (cmd_code == CMD_HS_EXIT && ok_hs_out) ||
                      (cmd_code == CMD_ULP_ENTER && st_q == ST_STOP) ||
                      (cmd_code == CMD_ULP_EXIT && st_q == ST_ULP) ||
                      (cmd_code == CMD_ESC && ok_esc));
    wire last_step = (idx_q + 5'h01 >= len_q);
    wire byte_end  = (bit_q == 3'(HS_BITS - 1));

    always_comb
    begin
      ld_steps = '0;
      ld_len   = '0;
      ld_nxt   = ST_STOP;
      case (cmd_code)
        CMD_HS_ENTER:
        begin
          ld_steps[0] = S_LP01;
          ld_steps[1] = S_LP00;
          ld_steps[2] = S_HS0;
          ld_len      = 5'h03;
          ld_nxt      = ST_HS;
        end
        CMD_HS_EXIT:
        begin
          ld_steps[0] = S_HS0;
          ld_steps[1] = S_LP11;
          ld_len      = 5'h02;
          ld_nxt      = ST_STOP;
        end
        CMD_ULP_ENTER:
        begin
          if (IS_CLK)
          begin
            ld_steps[0] = S_LP10;
            ld_steps[1] = S_LP00;
            ld_len      = 5'h02;
          end
          else
          begin
            ld_steps = esc_steps(ESC_ULPS);
            ld_len   = 5'(ESC_LEN);
          end
          ld_nxt = ST_ULP;
        end
        CMD_ULP_EXIT:
        begin
          ld_steps[0] = S_LP10;
          ld_steps[1] = S_LP11;
          ld_len      = 5'h02;
          ld_nxt      = ST_STOP;
        end
        CMD_ESC:
        begin
          ld_steps                  = esc_steps(cmd_esc);
          ld_steps[ESC_LEN]         = S_LP10;
          ld_steps[ESC_LEN + 1]     = S_LP11;
          ld_len                    = 5'(ESC_LEN + EXIT_LEN);
          ld_nxt                    = ST_STOP;
        end
        default:
        begin
          ld_len = '0;
        end
      endcase
    end

    // Sequencer state and step walk
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
      begin
        st_q    <= ST_STOP;
        nxt_q   <= ST_STOP;
        steps_q <= '0;
        len_q   <= '0;
        idx_q   <= '0;
        busy_q  <= 1'b0;
        start_q <= 1'b0;
        fin_q   <= 1'b0;
      end
      else
      begin
        start_q <= 1'b0;
        fin_q   <= 1'b0;
        case (st_q)
          ST_SEQ:
          begin
            if (tif.done && last_step)
            begin
              st_q   <= nxt_q;
              fin_q  <= 1'b1;
              busy_q <= 1'b0;
            end
            else if (tif.done)
            begin
              idx_q   <= idx_q + 5'h01;
              start_q <= 1'b1;
            end
          end
          default:
          begin
            if (ok)
            begin
              st_q    <= ST_SEQ;
              nxt_q   <= ld_nxt;
              steps_q <= ld_steps;
              len_q   <= ld_len;
              idx_q   <= '0;
              start_q <= 1'b1;
              busy_q  <= 1'b1;
            end
          end
        endcase
      end
    end

    assign tif.start = start_q;

    wire [2:0] cur_step = (st_q == ST_SEQ && tif.done && !last_step) ?
                          steps_q[idx_q + 5'h01] : steps_q[0];

    // Line drive; reset leaves every lane at stop
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
      begin
        pn_q  <= S_LP11[1:0];
        hs_q  <= 1'b0;
        oe_q  <= 1'b0;
        sh_q  <= '0;
        bit_q <= '0;
        take_q <= 1'b0;
      end
      else
      begin
        oe_q   <= 1'b1;
        take_q <= 1'b0;
        if (ok)
        begin
          pn_q <= ld_steps[0][1:0];
          hs_q <= ld_steps[0][2];
        end
        else if (st_q == ST_SEQ && tif.done && !last_step)
        begin
          pn_q <= cur_step[1:0];
          hs_q <= cur_step[2];
        end
        else if (st_q == ST_SEQ && tif.done && nxt_q == ST_HS && !IS_CLK)
        begin
          sh_q   <= {hs_byte[i][6:0], 1'b0};
          pn_q   <= {hs_byte[i][7], ~hs_byte[i][7]};
          bit_q  <= '0;
          take_q <= 1'b1;
        end
        else if (st_q == ST_HS && IS_CLK)
        begin
          pn_q <= ~pn_q;
        end
        else if (st_q == ST_HS)
        begin
          pn_q  <= byte_end ? {hs_byte[i][7], ~hs_byte[i][7]} : {sh_q[7], ~sh_q[7]};
          sh_q  <= byte_end ? {hs_byte[i][6:0], 1'b0} : {sh_q[6:0], 1'b0};
          bit_q <= bit_q + 3'h1;
          take_q <= byte_end;
        end
      end
    end

    assign st_arr[i] = st_q;
    assign acc_w[i]  = ok;
    assign fin_w[i]  = fin_q;
    assign take_w[i] = take_q;
    assign lane_p[i]    = pn_q[1];
    assign lane_n[i]    = pn_q[0];
    assign lane_hs[i]   = hs_q;
    assign lane_oe[i]   = oe_q;
    assign lane_busy[i] = busy_q;
  end

  // Far end drives lane 0 back only after turnaround; level is watched here
  // Inverted so the cleared synchroniser reads as stop, not a false bridge
  dls_sync2 #(.W(2)) u_rx_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (~{lane0_rx_p, lane0_rx_n}),
    .q       (rx_sync)
  );

  wire any_req = cmd_valid;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_done                   <= 1'b0;
      cmd_refused                <= 1'b0;
      hs_take                    <= '0;
      lane0_rx_state             <= S_LP11[1:0];
      clock_low_power_mode       <= 1'b1;
      clock_ultra_low_power_mode <= 1'b0;
      clock_high_speed_mode      <= 1'b0;
    end
    else
    begin
      cmd_done       <= |fin_w;
      cmd_refused    <= any_req && !(|acc_w);
      hs_take        <= {take_w[LANE_D1], take_w[LANE_D0]};
      lane0_rx_state <= ~rx_sync;
      // Mode holds while a sequence is still walking
      if (st_arr[LANE_CLK] != ST_SEQ)
      begin
        clock_low_power_mode       <= (st_arr[LANE_CLK] == ST_STOP);
        clock_ultra_low_power_mode <= (st_arr[LANE_CLK] == ST_ULP);
        clock_high_speed_mode      <= (st_arr[LANE_CLK] == ST_HS);
      end
    end
  end
endmodule : dls_host_ctrl
`default_nettype wire

//--- dv/dls_host_ctrl_assertions.sv
// Port-level timing checks of the host lane controller.
// Single reference clock domain; bound into every dls_host_ctrl.
`timescale 1ns/1ps
`default_nettype none
module dls_host_ctrl_assertions
  import dls_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic [1:0] cmd_lane,
  input wire logic [2:0] cmd_code,
  input wire logic       cmd_refused,
  input wire logic [2:0] lane_p,
  input wire logic [2:0] lane_n,
  input wire logic [2:0] lane_hs,
  input wire logic       clock_low_power_mode,
  input wire logic       clock_ultra_low_power_mode,
  input wire logic       clock_high_speed_mode
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic [1:0] ck;
  logic       ck_cmd;
  assign ck = {lane_p[0], lane_n[0]};
  assign ck_cmd = cmd_valid && cmd_lane == 2'h0;
  property p_reset_stop;
    $fell(rst) |-> lane_p == 3'h7 && lane_n == 3'h7 && clock_low_power_mode;
  endproperty
  a_reset_stop: assert property (p_reset_stop)
    else $error("lanes not stopped after reset");
  property p_one_mode;
    $onehot({clock_low_power_mode, clock_ultra_low_power_mode, clock_high_speed_mode});
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("clock lane mode not one-hot");
  property p_hs_diff;
    (lane_hs & ~(lane_p ^ lane_n)) == 3'h0;
  endproperty
  a_hs_diff: assert property (p_hs_diff)
    else $error("high-speed lane not differential");
  property p_esc_refuse;
    cmd_valid && cmd_code == CMD_ESC && cmd_lane != 2'h1 |=> cmd_refused;
  endproperty
  a_esc_refuse: assert property (p_esc_refuse)
    else $error("escape accepted on a lane without it");
  property p_hs_enter;
    ck_cmd && cmd_code == CMD_HS_ENTER ##1 !cmd_refused |-> (ck == 2'b01) [*3]
      ##1 (ck == 2'b00) [*3] ##1 (lane_hs[0] && ck == 2'b01);
  endproperty
  a_hs_enter: assert property (p_hs_enter)
    else $error("clock high-speed entry order wrong");
  property p_ulp_enter;
    ck_cmd && cmd_code == CMD_ULP_ENTER ##1 !cmd_refused |-> (ck == 2'b10) [*3]
      ##1 (ck == 2'b00) ##[1:6] clock_ultra_low_power_mode;
  endproperty
  a_ulp_enter: assert property (p_ulp_enter)
    else $error("clock ultra-low-power entry wrong");
  property p_ulp_exit;
    ck_cmd && cmd_code == CMD_ULP_EXIT ##1 !cmd_refused |-> (ck == 2'b10) [*3]
      ##1 (ck == 2'b11) ##[1:6] clock_low_power_mode;
  endproperty
  a_ulp_exit: assert property (p_ulp_exit)
    else $error("clock ultra-low-power exit wrong");
  property p_hs_exit;
    ck_cmd && cmd_code == CMD_HS_EXIT ##1 !cmd_refused |-> (lane_hs[0] && ck == 2'b01) [*3]
      ##1 (!lane_hs[0] && ck == 2'b11) ##[1:6] clock_low_power_mode;
  endproperty
  a_hs_exit: assert property (p_hs_exit)
    else $error("clock high-speed exit wrong");
  property p_clk_first;
    lane_hs[2:1] != 2'h0 |-> clock_high_speed_mode;
  endproperty
  a_clk_first: assert property (p_clk_first)
    else $error("data lane high-speed without clock");
endmodule : dls_host_ctrl_assertions
bind dls_host_ctrl dls_host_ctrl_assertions u_chk (.ref_clk, .rst, .cmd_valid, .cmd_lane,
  .cmd_code, .cmd_refused, .lane_p, .lane_n, .lane_hs, .clock_low_power_mode,
  .clock_ultra_low_power_mode, .clock_high_speed_mode);
`default_nettype wire

//--- dv/dls_disp_model.sv
// Display-end model: decodes lane line states, escape bytes and clock lane mode.
// Samples host pins on the reference clock; never turns data lane 0 around.
`timescale 1ns/1ps
`default_nettype none
module dls_disp_model
  import dls_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [2:0] lane_p,
  input  wire logic [2:0] lane_n,
  input  wire logic [2:0] lane_hs,
  output logic      [2:0] term_en,
  output logic      [2:0] clk_mode,
  output logic [2:0][7:0] esc_byte
);
  logic [2:0] h0 [3];
  logic [2:0] h1 [3];
  logic [2:0] cur;
  logic       ent [3];
  int         bits [3];
  assign term_en = lane_hs;
  always @(posedge ref_clk or posedge rst)
  begin
    for (int k = 0; k < 3; k++)
    begin
      cur = {lane_hs[k], lane_p[k], lane_n[k]};
      if (rst || cur == S_LP11)
      begin
        ent[k] = 1'b0;
        bits[k] = 0;
        if (k == 0)
          clk_mode = 3'h1;
      end
      else if (k == 0 && cur == S_LP00 && h0[0] == S_LP10 && h1[0] == S_LP11)
        clk_mode = 3'h2;
      else if (k == 0 && cur[2] && h0[0] == S_LP00 && h1[0] == S_LP01)
        clk_mode = 3'h4;
      else if (cur != h0[k] && h0[k] == S_LP00 && (cur == S_LP01 || cur == S_LP10))
      begin
        // First mark after space is the entry; later marks are bits
        if (!ent[k])
          ent[k] = 1'b1;
        else if (bits[k] < 8)
        begin
          esc_byte[k] = {esc_byte[k][6:0], cur == S_LP10};
          bits[k]++;
        end
      end
      if (rst || cur != h0[k])
      begin
        h1[k] = rst ? S_LP11 : h0[k];
        h0[k] = rst ? S_LP11 : cur;
      end
    end
  end
endmodule : dls_disp_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the host lane controller against the display model.
// Lane commands with random escape and burst bytes; codes from dls_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dls_pkg::*;
  ;
  localparam logic [4:0] BAD [7] = '{{2'h0, CMD_ESC}, {2'h2, CMD_ESC}, {2'h0, CMD_HS_EXIT},
                                     {2'h0, CMD_ULP_EXIT}, {2'h1, CMD_HS_ENTER},
                                     {2'h3, CMD_ULP_ENTER}, {2'h1, 3'h7}};
  logic            ref_clk;
  logic            rst;
  logic            cmd_valid;
  logic      [1:0] cmd_lane;
  logic      [2:0] cmd_code;
  logic      [7:0] cmd_esc;
  logic            cmd_done;
  logic            cmd_refused;
  logic [1:0][7:0] hs_in;
  logic      [1:0] hs_take;
  logic      [2:0] lane_busy;
  logic      [8:0] hs_sr [2];
  logic      [7:0] hs_exp [2];
  logic      [1:0] hs_seen;
  logic      [2:0] lane_p;
  logic      [2:0] lane_n;
  logic      [2:0] lane_oe;
  logic      [2:0] lane_hs;
  logic      [1:0] rx_state;
  wire       [2:0] mode;
  logic      [2:0] term_en;
  logic      [2:0] m_mode;
  logic [2:0][7:0] m_esc;
  logic            lane0_rx_p;
  logic            lane0_rx_n;
  int              seed;
  int              fail_count;
  int              samples_checked;
  int              cyc = 0;
  // Device never drives back, so a released line shows a moving pattern
  assign lane0_rx_p = lane_oe[1] ? lane_p[1] : cyc[0];
  assign lane0_rx_n = lane_oe[1] ? lane_n[1] : ~cyc[0];
  dls_host_ctrl DUT (.ref_clk, .rst, .cmd_valid, .cmd_lane, .cmd_code, .cmd_esc, .cmd_done,
    .cmd_refused, .hs_byte0(hs_in[0]), .hs_byte1(hs_in[1]), .hs_take, .lane_p, .lane_n,
    .lane_oe, .lane_hs, .lane_busy, .lane0_rx_p, .lane0_rx_n, .lane0_rx_state(rx_state),
    .clock_low_power_mode(mode[0]), .clock_ultra_low_power_mode(mode[1]),
    .clock_high_speed_mode(mode[2]));
  dls_disp_model u_disp (.ref_clk, .rst, .lane_p, .lane_n, .lane_hs, .term_en,
    .clk_mode(m_mode), .esc_byte(m_esc));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  // Burst bytes change only in reset or after a take, so the expected byte is known
  always @(negedge ref_clk)
  begin
    for (int k = 0; k < 2; k++)
    begin
      hs_sr[k] <= {hs_sr[k][7:0], lane_p[k + 1]};
      if (hs_take[k] === 1'b1 && hs_seen[k])
        chk(hs_sr[k][8:1], hs_exp[k]);
      if (hs_take[k] === 1'b1)
        hs_exp[k] <= hs_in[k];
      if (rst || hs_take[k] === 1'b1)
        hs_in[k] <= 8'($random(seed));
      hs_seen[k] <= (hs_take[k] === 1'b1 || hs_seen[k]) && lane_hs[k + 1];
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [2:0] mode_of(input logic [2:0] code);
    case (code)
      CMD_HS_ENTER:  return 3'h4;
      CMD_ULP_ENTER: return 3'h2;
      default:       return 3'h1;
    endcase
  endfunction : mode_of
  task automatic req(input logic [1:0] ln, input logic [2:0] code, input logic [7:0] esc,
                     input logic ok);
    int n;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_lane = ln;
    cmd_code = code;
    cmd_esc = esc;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    chk((32'(lane_busy) >> ln) & 32'h1, ok);
    n = 0;
    while (!(cmd_done === 1'b1 || cmd_refused === 1'b1) && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(cmd_done, ok);
    chk(cmd_refused, !ok);
  endtask : req
  task automatic clk_step(input logic [2:0] code);
    req(2'h0, code, 8'h00, 1'b1);
    repeat (2) @(negedge ref_clk);
    chk(mode, mode_of(code));
    chk(m_mode, mode_of(code));
  endtask : clk_step
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    seed = 32'h4561;
    fail_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    {cmd_valid, cmd_lane, cmd_code, cmd_esc} = '0;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk({mode, m_mode, lane_p, lane_n}, 12'h27f);
    for (int i = 0; i < 7; i++)
      req(BAD[i][4:3], BAD[i][2:0], 8'h00, 1'b0);
    $display("test refusals done");
    clk_step(CMD_ULP_ENTER);
    clk_step(CMD_ULP_EXIT);
    $display("test clock ultra-low-power done");
    for (int i = 0; i < 4; i++)
    begin
      req(2'h1, CMD_ESC, i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed)), 1'b1);
      chk(m_esc[1], cmd_esc);
    end
    req(2'h2, CMD_ULP_ENTER, 8'h00, 1'b1);
    chk(m_esc[2], ESC_ULPS);
    req(2'h2, CMD_ULP_EXIT, 8'h00, 1'b1);
    chk(rx_state, 2'h3);
    $display("test escapes done");
    clk_step(CMD_HS_ENTER);
    req(2'h1, CMD_HS_ENTER, 8'h00, 1'b1);
    req(2'h2, CMD_HS_ENTER, 8'h00, 1'b1);
    chk(term_en, 3'h7);
    repeat (40) @(negedge ref_clk);
    req(2'h0, CMD_HS_EXIT, 8'h00, 1'b0);
    req(2'h1, CMD_HS_EXIT, 8'h00, 1'b1);
    req(2'h2, CMD_HS_EXIT, 8'h00, 1'b1);
    clk_step(CMD_HS_EXIT);
    $display("test high-speed done");
    clk_step(CMD_HS_ENTER);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk({mode, m_mode, lane_p, lane_n}, 12'h27f);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
